/* File: verilog/intr_ctrl_regs.svh */
`ifndef INTR_CTRL_REGS_SVH
`define INTR_CTRL_REGS_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define OFS_INTERRUPT_STATUS      9'h000
`define OFS_INTERRUPT_PENDING     9'h004
`define OFS_INTERRUPT_ENABLE      9'h008
`define OFS_INTERRUPT_ACKNOWLEDGE 9'h00C
`define OFS_SET_ENABLES           9'h010
`define OFS_CLEAR_ENABLES         9'h014
`define OFS_INTERRUPT_VECTOR      9'h018
`define OFS_MASTER_ENABLE         9'h01C
`define OFS_INTERRUPT_MODE        9'h020
`define OFS_INTERRUPT_LEVEL       9'h024
`define OFS_VECTOR_ADDR_FIRST     9'h100
`define OFS_VECTOR_ADDR_LAST      9'h170

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define MER_MASTER_BIT            0
`define MER_HW_ENABLE_BIT         1
`define RST_WORD                  32'h0000_0000
`define NO_VECTOR                 32'hFFFF_FFFF

// ****************************************************************
// AXI response codes
// ****************************************************************
`define RESP_OKAY                 2'h0
`define RESP_SLVERR               2'h2

`endif

/* File: verilog/intr_ctrl_pkg.sv */
package intr_ctrl_pkg;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef logic [31:0] word_t;

  typedef struct packed
  {
    logic [8:0] addr;
    word_t      data;
    logic [3:0] strb;
  } wr_req_s;

  typedef enum logic [1:0]
  {
    WR_IDLE = 2'b00,
    WR_RESP = 2'b01
  } wr_state_e;

endpackage : intr_ctrl_pkg

/* File: verilog/interrupt_status_regmap.sv */
// Operation
// R1: Fast vector/ack ports only with fast option
// R2: Fast option needs other options zero
// R3: Single-wire output forbids fast option
// R4: Cascade vector/ack ports per fast/cascade/primary
// R5: Cascade request input only with cascade
// R6: Bus widths follow data/address parameters
// R7: Removed features: inputs ignored, outputs fixed
// R8: Word-aligned AXI4-Lite access, little-endian data
// R9: Decode status through level, vector array
// R10: Status reads one for active interrupts
// R11: Hardware bits low, software bits above
// R12: Status capture ignores enable bits
// R13: Hardware status writes blocked once enabled
// R14: Status write sets bits written one
// R15: Unconfigured status bits read zero
// R16: Pending is status AND enable
// R17: Acknowledge one clears status bit
// R18: Inputs set status by edge/level
`include "intr_ctrl_regs.svh"

module interrupt_status_regmap
  import intr_ctrl_pkg::*;
#(
  parameter int          ADDR_WIDTH  = 9,
  parameter int          DATA_WIDTH  = 32,
  parameter int          HW_INPUTS   = 1,
  parameter int          SW_INTS     = 0,
  parameter logic [31:0] KIND_EDGE   = 32'hFFFF_FFFF,
  parameter logic [31:0] EDGE_RISING = 32'hFFFF_FFFF,
  parameter logic [31:0] LEVEL_HIGH  = 32'hFFFF_FFFF,
  parameter bit          HAS_FAST    = 1'b0,
  parameter bit          EN_CASCADE  = 1'b0,
  parameter bit          CASCADE_PRI = 1'b0
)
(
  // Clock and reset
  input  wire logic                      sys_clk_i,
  input  wire logic                      arst_n_i,
  // AXI4-Lite write address, data and response
  input  wire logic [ADDR_WIDTH-1:0]     s_axi_awaddr_i,
  input  wire logic                      s_axi_awvalid_i,
  output logic                           s_axi_awready_o,
  input  wire logic [DATA_WIDTH-1:0]     s_axi_wdata_i,
  input  wire logic [DATA_WIDTH/8-1:0]   s_axi_wstrb_i, // R6
  input  wire logic                      s_axi_wvalid_i,
  output logic                           s_axi_wready_o,
  output logic [1:0]                     s_axi_bresp_o,
  output logic                           s_axi_bvalid_o,
  input  wire logic                      s_axi_bready_i,
  // AXI4-Lite read
  input  wire logic [ADDR_WIDTH-1:0]     s_axi_araddr_i,
  input  wire logic                      s_axi_arvalid_i,
  output logic                           s_axi_arready_o,
  output logic [DATA_WIDTH-1:0]          s_axi_rdata_o,
  output logic [1:0]                     s_axi_rresp_o,
  output logic                           s_axi_rvalid_o,
  input  wire logic                      s_axi_rready_i,
  // Peripheral interrupt lines
  input  wire logic [31:0]               intr_i,
  // Fast interrupt ports
  output logic [31:0]                    vector_address_o,
  input  wire logic [1:0]                processor_ack_i,
  // Cascade ports
  input  wire logic [31:0]               cascade_vector_address_i,
  output logic [1:0]                     cascade_ack_o,
  input  wire logic                      cascade_irq_i,
  // Status view
  output logic [31:0]                    interrupt_status_o
);

  // ****************************************************************
  // Configuration masks
  // ****************************************************************
  localparam int          TOTAL   = HW_INPUTS + SW_INTS;
  localparam logic [31:0] HW_MASK = 32'hFFFF_FFFF >> (32 - HW_INPUTS);
  localparam logic [31:0] ALL_MSK = (TOTAL >= 32) ? 32'hFFFF_FFFF :
                                    (32'hFFFF_FFFF >> (32 - TOTAL));
  localparam logic [31:0] SW_MASK = ALL_MSK & ~HW_MASK;
  // Fast acknowledge is passed downward only by a cascaded non-primary stage.
  localparam bit          CAS_VEC = HAS_FAST && EN_CASCADE && !CASCADE_PRI;

  // ****************************************************************
  // Input synchronisers and sense detection
  // ****************************************************************
  logic [31:0] intr_meta;
  logic [31:0] intr_sync;
  logic [31:0] intr_prev;
  logic [31:0] hw_event;
  logic        casc_meta;
  logic        casc_sync;

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      intr_meta <= `RST_WORD;
      intr_sync <= `RST_WORD;
      intr_prev <= `RST_WORD;
      casc_meta <= 1'b0;
      casc_sync <= 1'b0;
    end
    else
    begin
      intr_meta <= intr_i;
      intr_sync <= intr_meta;
      intr_prev <= intr_sync;
      casc_meta <= EN_CASCADE ? cascade_irq_i : 1'b0; // R5 R7
      casc_sync <= casc_meta;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++)
    begin : g_sense
      always_comb
      begin
        if (KIND_EDGE[gi])
          hw_event[gi] = EDGE_RISING[gi] ? (intr_sync[gi] & ~intr_prev[gi])
                                         : (~intr_sync[gi] & intr_prev[gi]); // R18
        else
          hw_event[gi] = LEVEL_HIGH[gi] ? intr_sync[gi] : ~intr_sync[gi]; // R18
      end
    end
  endgenerate

  // ****************************************************************
  // Write channel
  // ****************************************************************
  wr_state_e   wr_state;
  wr_state_e   next_wr_state;
  logic        aw_held;
  logic        next_aw_held;
  logic        w_held;
  logic        next_w_held;
  wr_req_s     wr;
  wr_req_s     next_wr;
  logic        wr_fire;
  logic [31:0] wmask;

  // Address and data may arrive in either order; each is held until both are.
  always_comb
  begin
    next_wr_state = wr_state;
    next_aw_held  = aw_held;
    next_w_held   = w_held;
    next_wr       = wr;
    wr_fire       = 1'b0;
    case (wr_state)
      WR_IDLE:
      begin
        // Nothing is taken before its ready has been shown at the same edge.
        if (s_axi_awvalid_i && s_axi_awready_o)
        begin
          next_aw_held = 1'b1;
          next_wr.addr = s_axi_awaddr_i[8:0];
        end
        if (s_axi_wvalid_i && s_axi_wready_o)
        begin
          next_w_held  = 1'b1;
          next_wr.data = s_axi_wdata_i;
          next_wr.strb = s_axi_wstrb_i;
        end
        if (aw_held && w_held)
        begin
          wr_fire       = 1'b1;
          next_aw_held  = 1'b0;
          next_w_held   = 1'b0;
          next_wr_state = WR_RESP;
        end
      end
      WR_RESP:
      begin
        if (s_axi_bready_i)
          next_wr_state = WR_IDLE;
      end
      default:
        next_wr_state = WR_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wr_state <= WR_IDLE;
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      wr       <= '0;
    end
    else
    begin
      wr_state <= next_wr_state;
      aw_held  <= next_aw_held;
      w_held   <= next_w_held;
      wr       <= next_wr;
    end
  end

  // Byte lanes are little-endian: strobe bit k covers data bits 8k+7..8k.
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_lane
      assign wmask[8*gi +: 8] = {8{wr.strb[gi]}} & wr.data[8*gi +: 8]; // R8
    end
  endgenerate

  // ****************************************************************
  // Register state
  // ****************************************************************
  word_t status;
  word_t next_status;
  word_t enable;
  word_t next_enable;
  logic [1:0] master;
  logic [1:0] next_master;
  word_t mode;
  word_t next_mode;
  word_t level;
  word_t next_level;
  word_t vec_addr [0:31];
  logic  wr_ok;
  logic  is_vec;
  logic [4:0] vec_idx;
  word_t ack_bits;

  assign is_vec  = (wr.addr >= `OFS_VECTOR_ADDR_FIRST) && (wr.addr <= `OFS_VECTOR_ADDR_LAST)
                   && (wr.addr[1:0] == 2'b00); // R9
  assign vec_idx = 5'(wr.addr[6:2]);
  // Misaligned addresses never match a register and are answered with an error.
  assign wr_ok   = (wr.addr[1:0] == 2'b00) && ((wr.addr <= `OFS_INTERRUPT_LEVEL) || is_vec); // R8

  always_comb
  begin
    next_status = status;
    next_enable = enable;
    next_master = master;
    next_mode   = mode;
    next_level  = level;
    ack_bits    = '0;
    if (wr_fire)
    begin
      if (wr.addr == `OFS_INTERRUPT_STATUS)
      begin
        if (master[`MER_HW_ENABLE_BIT])
          next_status = status | (wmask & SW_MASK); // R13
        else
          next_status = status | (wmask & ALL_MSK); // R14 R15
      end
      else if (wr.addr == `OFS_INTERRUPT_ENABLE)
        next_enable = wmask & ALL_MSK;
      else if (wr.addr == `OFS_INTERRUPT_ACKNOWLEDGE)
        ack_bits = wmask; // R17
      else if (wr.addr == `OFS_SET_ENABLES)
        next_enable = enable | (wmask & ALL_MSK);
      else if (wr.addr == `OFS_CLEAR_ENABLES)
        next_enable = enable & ~wmask;
      else if (wr.addr == `OFS_MASTER_ENABLE)
        // Once set, the hardware enable bit stays set until reset.
        next_master = {master[`MER_HW_ENABLE_BIT] | wmask[`MER_HW_ENABLE_BIT],
                       wmask[`MER_MASTER_BIT]};
      else if (wr.addr == `OFS_INTERRUPT_MODE)
        next_mode = HAS_FAST ? (wmask & ALL_MSK) : `RST_WORD; // R7
      else if (wr.addr == `OFS_INTERRUPT_LEVEL)
        next_level = wmask;
    end
    if (HAS_FAST && processor_ack_i == 2'b01 && mode[0])
      ack_bits = ack_bits | 32'h0000_0001; // R1
    // Events win over a simultaneous acknowledge, so none is lost.
    next_status = ((next_status & ~ack_bits) | (hw_event & HW_MASK)) & ALL_MSK; // R12 R17 R11
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      status <= `RST_WORD;
      enable <= `RST_WORD;
      master <= 2'b00;
      mode   <= `RST_WORD;
      level  <= `RST_WORD;
    end
    else
    begin
      status <= next_status;
      enable <= next_enable;
      master <= next_master;
      mode   <= next_mode;
      level  <= next_level;
    end
  end

  // The vector array holds no reset so it can map to plain memory.
  always_ff @(posedge sys_clk_i)
  begin
    if (wr_fire && is_vec && HAS_FAST)
      vec_addr[vec_idx] <= wr.data; // R9 R7
  end

  // ****************************************************************
  // Read channel
  // ****************************************************************
  word_t       pending;
  word_t       vector;
  word_t       rd_data;
  logic        rd_ok;
  logic [8:0]  ra;
  logic        rvalid;
  logic        next_rvalid;
  word_t       rdata;
  word_t       next_rdata;
  logic [1:0]  rresp;
  logic [1:0]  next_rresp;

  assign pending = status & enable; // R16
  assign ra      = s_axi_araddr_i[8:0];

  always_comb
  begin
    vector = `NO_VECTOR;
    for (int i = 31; i >= 0; i--)
    begin
      if (pending[i])
        vector = 32'(i);
    end
  end

  always_comb
  begin
    rd_data = `RST_WORD;
    rd_ok   = (ra[1:0] == 2'b00); // R8
    if (!rd_ok)
      rd_data = `RST_WORD;
    else if (ra == `OFS_INTERRUPT_STATUS)
      rd_data = status & ALL_MSK; // R10 R15
    else if (ra == `OFS_INTERRUPT_PENDING)
      rd_data = pending; // R16
    else if (ra == `OFS_INTERRUPT_ENABLE)
      rd_data = enable;
    else if (ra == `OFS_INTERRUPT_VECTOR)
      rd_data = vector;
    else if (ra == `OFS_MASTER_ENABLE)
      rd_data = {30'h0000_0000, master};
    else if (ra == `OFS_INTERRUPT_MODE)
      rd_data = mode;
    else if (ra == `OFS_INTERRUPT_LEVEL)
      rd_data = level;
    else if (ra >= `OFS_VECTOR_ADDR_FIRST && ra <= `OFS_VECTOR_ADDR_LAST)
      rd_data = HAS_FAST ? vec_addr[ra[6:2]] : `RST_WORD; // R9 R7
    else if (ra == `OFS_INTERRUPT_ACKNOWLEDGE || ra == `OFS_SET_ENABLES
             || ra == `OFS_CLEAR_ENABLES)
      rd_data = `RST_WORD;
    else
      rd_ok = 1'b0;
  end

  always_comb
  begin
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (rvalid && s_axi_rready_i)
      next_rvalid = 1'b0;
    else if (!rvalid && s_axi_arvalid_i && s_axi_arready_o)
    begin
      next_rvalid = 1'b1;
      next_rdata  = rd_data;
      next_rresp  = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end
  end

  // ****************************************************************
  // Output registers
  // ****************************************************************
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rvalid             <= 1'b0;
      rdata              <= `RST_WORD;
      rresp              <= `RESP_OKAY;
      s_axi_awready_o    <= 1'b0;
      s_axi_wready_o     <= 1'b0;
      s_axi_bvalid_o     <= 1'b0;
      s_axi_bresp_o      <= `RESP_OKAY;
      s_axi_arready_o    <= 1'b0;
      vector_address_o   <= `RST_WORD;
      cascade_ack_o      <= 2'b00;
      interrupt_status_o <= `RST_WORD;
    end
    else
    begin
      rvalid             <= next_rvalid;
      rdata              <= next_rdata;
      rresp              <= next_rresp;
      s_axi_awready_o    <= (wr_state == WR_IDLE) && !aw_held && !s_axi_awready_o
                            && s_axi_awvalid_i;
      s_axi_wready_o     <= (wr_state == WR_IDLE) && !w_held && !s_axi_wready_o
                            && s_axi_wvalid_i;
      s_axi_bvalid_o     <= (next_wr_state == WR_RESP);
      if (wr_fire)
        s_axi_bresp_o    <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      s_axi_arready_o    <= !rvalid && s_axi_arvalid_i && !s_axi_arready_o;
      vector_address_o   <= HAS_FAST ? (vector == `NO_VECTOR ? `RST_WORD
                             : vec_addr[vector[4:0]]) : `RST_WORD; // R1 R7
      cascade_ack_o      <= CAS_VEC ? processor_ack_i : 2'b00; // R4 R7
      interrupt_status_o <= status;
    end
  end

  assign s_axi_rvalid_o = rvalid;
  assign s_axi_rdata_o  = rdata;
  assign s_axi_rresp_o  = rresp;

endmodule : interrupt_status_regmap

/* File: test/interrupt_status_regmap_chk.sv */
`include "intr_ctrl_regs.svh"

module interrupt_status_regmap_chk
  import intr_ctrl_pkg::*;
#(
  parameter int ADDR_WIDTH  = 9,
  parameter int DATA_WIDTH  = 32,
  parameter int HW_INPUTS   = 1,
  parameter int SW_INTS     = 0,
  parameter bit HAS_FAST    = 1'b0,
  parameter bit EN_CASCADE  = 1'b0,
  parameter bit CASCADE_PRI = 1'b0
)
(
  // Clock and reset
  input wire logic                  sys_clk_i,
  input wire logic                  arst_n_i,
  // Bus
  input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr_i,
  input wire logic [1:0]            s_axi_bresp_o,
  input wire logic                  s_axi_bvalid_o,
  input wire logic                  s_axi_bready_i,
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr_i,
  input wire logic                  s_axi_arvalid_i,
  input wire logic                  s_axi_arready_o,
  input wire logic [DATA_WIDTH-1:0] s_axi_rdata_o,
  input wire logic [1:0]            s_axi_rresp_o,
  input wire logic                  s_axi_rvalid_o,
  input wire logic                  s_axi_rready_i,
  // Interrupt side
  input wire logic [31:0]           intr_i,
  input wire logic [31:0]           vector_address_o,
  input wire logic [1:0]            cascade_ack_o,
  input wire logic [31:0]           interrupt_status_o
);
  localparam logic [32:0] USED = (33'h1 << (HW_INPUTS + SW_INTS)) - 33'h1;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence read_taken;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  sequence read_answered;
    s_axi_rvalid_o;
  endsequence

  a_read_answer: assert property (read_taken |=> read_answered)
    else $error("read not answered after one cycle");
  a_read_misaligned: assert property (
    read_taken and (s_axi_araddr_i[1:0] != 2'h0) |=>
      s_axi_rresp_o == `RESP_SLVERR && s_axi_rdata_o == '0)
    else $error("misaligned read not refused");
  a_read_hold: assert property (
    s_axi_rvalid_o && !s_axi_rready_i |=>
      s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
    else $error("read answer dropped early");
  a_write_hold: assert property (
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write answer dropped early");
  a_write_misaligned: assert property (
    $rose(s_axi_bvalid_o) && s_axi_awaddr_i[1:0] != 2'h0 |-> s_axi_bresp_o == `RESP_SLVERR)
    else $error("misaligned write not refused");
  a_unused_zero: assert property ((interrupt_status_o & ~USED[31:0]) == 32'h0)
    else $error("unconfigured status bit set");
  a_fast_off: assert property (!HAS_FAST |-> vector_address_o == 32'h0)
    else $error("vector output not tied");
  a_cascade_off: assert property (
    !(HAS_FAST && EN_CASCADE && !CASCADE_PRI) |-> cascade_ack_o == 2'h0)
    else $error("cascade acknowledge not tied");
  a_edge_sets: assert property ($rose(intr_i[0]) |-> ##[3:5] interrupt_status_o[0])
    else $error("input edge not captured");
  a_clear_by_ack: assert property (
    $fell(interrupt_status_o[0]) |-> s_axi_bvalid_o || $past(s_axi_bvalid_o))
    else $error("status cleared without a write");
endmodule : interrupt_status_regmap_chk

bind interrupt_status_regmap interrupt_status_regmap_chk #(
  .ADDR_WIDTH(ADDR_WIDTH), .DATA_WIDTH(DATA_WIDTH), .HW_INPUTS(HW_INPUTS),
  .SW_INTS(SW_INTS), .HAS_FAST(HAS_FAST), .EN_CASCADE(EN_CASCADE), .CASCADE_PRI(CASCADE_PRI)
) u_chk (
  .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .s_axi_awaddr_i(s_axi_awaddr_i),
  .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_araddr_i(s_axi_araddr_i),
  .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i), .intr_i(intr_i),
  .vector_address_o(vector_address_o), .cascade_ack_o(cascade_ack_o),
  .interrupt_status_o(interrupt_status_o)
);

/* File: test/intr_source.sv */
module intr_source
(
  // Clock
  input  wire logic        sys_clk_i,
  // Peripheral lines
  output logic      [31:0] intr_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial intr_o = 32'h0;

  // The line is held two cycles so the two-stage synchroniser cannot miss it.
  task automatic pulse(input int idx);
    @(negedge sys_clk_i);
    intr_o[idx] = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    intr_o[idx] = 1'b0;
    repeat (6) @(negedge sys_clk_i);
  endtask : pulse
endmodule : intr_source

/* File: test/testbench.sv */
`include "intr_ctrl_regs.svh"

module testbench
  import intr_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        sys_clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic [8:0]  awaddr = 9'h0;
  logic [8:0]  araddr = 9'h0;
  word_t       wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [1:0]  pack = 2'h0;
  logic [3:0]  wstrb = 4'hF;
  word_t       cvec = 32'h0;
  logic        cirq = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, cack;
  word_t       rdata, vaddr, status, intr;
  int          n_mismatch = 0;
  int          check_count = 0;

  always #25 sys_clk_i = ~sys_clk_i;

  // Fast mode stays off, so the clock and output-style options are unconstrained.
  interrupt_status_regmap #(.HW_INPUTS(4), .SW_INTS(2)) uut (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .intr_i(intr), .vector_address_o(vaddr),
    .processor_ack_i(pack), .cascade_vector_address_i(cvec), .cascade_ack_o(cack),
    .cascade_irq_i(cirq), .interrupt_status_o(status)
  );

  intr_source src (.sys_clk_i(sys_clk_i), .intr_o(intr));

  task automatic cmp_word(input word_t got, input word_t exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t word %h expected %h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t response %h expected %h", $time, got, exp);
    end
  endtask : cmp_resp

  // The address stays on the bus after the handshake so the checker can relate the answer.
  task automatic wr(input logic [8:0] a, input word_t d, input logic [1:0] e);
    bit aw_ok;
    bit w_ok;
    int n;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    n = 0;
    @(negedge sys_clk_i);
    awaddr = a;
    wdata = d;
    awvalid = 1'b1;
    wvalid = 1'b1;
    while (!(aw_ok && w_ok) && n < 20)
    begin
      @(posedge sys_clk_i);
      aw_ok |= (awready === 1'b1);
      w_ok |= (wready === 1'b1);
      @(negedge sys_clk_i);
      awvalid = awvalid && !aw_ok;
      wvalid = wvalid && !w_ok;
      n++;
    end
    while (bvalid !== 1'b1 && n < 40)
    begin
      @(negedge sys_clk_i);
      n++;
    end
    cmp_word({31'h0, bvalid}, 32'h1);
    @(negedge sys_clk_i);
    bready = 1'b1;
    @(posedge sys_clk_i);
    cmp_resp(bresp, e);
    @(negedge sys_clk_i);
    bready = 1'b0;
  endtask : wr

  task automatic rd(input logic [8:0] a, input word_t d, input logic [1:0] e);
    int n;
    n = 0;
    @(negedge sys_clk_i);
    araddr = a;
    arvalid = 1'b1;
    do
    begin
      @(posedge sys_clk_i);
      n++;
    end
    while (arready !== 1'b1 && n < 20);
    @(negedge sys_clk_i);
    arvalid = 1'b0;
    @(negedge sys_clk_i);
    rready = 1'b1;
    cmp_word({31'h0, rvalid}, 32'h1);
    @(posedge sys_clk_i);
    cmp_word(rdata, d);
    cmp_resp(rresp, e);
    @(negedge sys_clk_i);
    rready = 1'b0;
  endtask : rd

  task automatic tally_and_finish();
    if (n_mismatch == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (20) @(negedge sys_clk_i);
    arst_n_i = 1'b1;
    rd(`OFS_INTERRUPT_STATUS, `RST_WORD, `RESP_OKAY);
    rd(`OFS_INTERRUPT_ACKNOWLEDGE, `RST_WORD, `RESP_OKAY);
    cmp_word(vaddr, 32'h0);
    wr(`OFS_INTERRUPT_STATUS, 32'hFFFF_FFFF, `RESP_OKAY);
    rd(`OFS_INTERRUPT_STATUS, 32'h0000_003F, `RESP_OKAY);
    wr(`OFS_INTERRUPT_ENABLE, 32'h0000_0003, `RESP_OKAY);
    rd(`OFS_INTERRUPT_PENDING, 32'h0000_0003, `RESP_OKAY);
    wstrb = 4'hE;
    wr(`OFS_SET_ENABLES, 32'h0000_003C, `RESP_OKAY);
    wstrb = 4'hF;
    rd(`OFS_INTERRUPT_ENABLE, 32'h0000_0003, `RESP_OKAY);
    rd(`OFS_INTERRUPT_STATUS, 32'h0000_003F, `RESP_OKAY);
    wr(`OFS_INTERRUPT_ACKNOWLEDGE, 32'h0000_003F, `RESP_OKAY);
    rd(`OFS_INTERRUPT_STATUS, 32'h0000_0000, `RESP_OKAY);
    wr(`OFS_MASTER_ENABLE, 32'h0000_0003, `RESP_OKAY);
    wr(`OFS_INTERRUPT_STATUS, 32'h0000_003F, `RESP_OKAY);
    rd(`OFS_INTERRUPT_STATUS, 32'h0000_0030, `RESP_OKAY);
    wr(`OFS_INTERRUPT_ACKNOWLEDGE, 32'h0000_0030, `RESP_OKAY);
    pack = 2'h1;
    cvec = 32'hA5A5_5A5A;
    cirq = 1'b1;
    src.pulse(0);
    src.pulse(2);
    src.pulse(4);
    rd(`OFS_INTERRUPT_STATUS, 32'h0000_0005, `RESP_OKAY);
    cmp_word(status, 32'h0000_0005);
    cmp_word({30'h0, cack}, 32'h0);
    rd(`OFS_INTERRUPT_PENDING, 32'h0000_0001, `RESP_OKAY);
    wr(`OFS_INTERRUPT_ACKNOWLEDGE, 32'h0000_0005, `RESP_OKAY);
    rd(9'h002, 32'h0, `RESP_SLVERR);
    rd(9'h030, 32'h0, `RESP_SLVERR);
    wr(9'h001, 32'h0000_003F, `RESP_SLVERR);
    rd(`OFS_INTERRUPT_STATUS, 32'h0000_0000, `RESP_OKAY);
    tally_and_finish();
  end

  // About twenty-two bus cycles of half a dozen clocks each fit well inside this span.
  initial
  begin
    #(3000 * 50);
    n_mismatch++;
    tally_and_finish();
  end
endmodule : testbench
